/* apf_pkg.sv */
// Constants, register map and types for the amplifier protection fault manager.
// Assumes a single 100 MHz core clock and a register port fed by the I2C slave.
package apf_pkg;
    localparam int          NUM_CH          = 4;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          DIAG_RETRY_MS   = 1000;
    // Register offsets
    localparam logic [7:0]  ADDR_MISC_ONE   = 8'h01;
    localparam logic [7:0]  ADDR_OC_ERR     = 8'h10;
    localparam logic [7:0]  ADDR_CH_ERR     = 8'h11;
    localparam logic [7:0]  ADDR_GLOB_ERR   = 8'h12;
    localparam logic [7:0]  ADDR_WARN_FLAGS = 8'h13;
    localparam logic [7:0]  ADDR_PIN_MASKS  = 8'h14;
    localparam logic [7:0]  ADDR_MISC_THREE = 8'h21;
    localparam logic [7:0]  ADDR_CLIP_WIN   = 8'h23;
    localparam logic [7:0]  ADDR_CAP_STAT   = 8'h25;
    // Reset values
    localparam logic [7:0]  RST_MISC_ONE    = 8'h00;
    localparam logic [7:0]  RST_PIN_MASKS   = 8'h00;
    localparam logic [7:0]  RST_CLIP_WIN    = 8'h14;
    localparam logic        RST_DIAG_EN     = 1'b1;
    // misc_control_one fields
    localparam int          M1_CAP_LEVEL    = 4;
    localparam int          M1_CAUTION_LO   = 5;
    // misc_control_three fields
    localparam int          M3_CLEAR        = 7;
    localparam int          M3_AUTO_RECOVER = 3;
    localparam int          M3_CLIP_NOLATCH = 2;
    localparam int          M3_DIAG_EN      = 0;
    // alert_pin_masks fields
    localparam int          MK_CLIP         = 0;
    localparam int          MK_CAUTION      = 1;
    localparam int          MK_CAP          = 2;
    localparam int          MK_DC           = 3;
    localparam int          MK_OC           = 4;
    localparam int          MK_THERM        = 5;
    localparam int          MK_SUPPLY       = 6;
    // Global error register fields
    localparam int          GE_OUT_LOW      = 0;
    localparam int          GE_BAT_LOW      = 1;
    localparam int          GE_HIGH         = 2;
    localparam int          GE_THERM        = 3;
    // Warning flag fields above the channel bits
    localparam int          WF_GLOBAL       = 4;
    localparam int          WF_RESTART      = 5;
    localparam int          WF_CLIP         = 6;

    typedef enum logic [1:0] {
        OC_PLAY,
        OC_TRIPPED,
        OC_DIAG,
        OC_WAIT
    } apf_oc_state_t;
endpackage : apf_pkg

/* apf_fault_manager.sv */
// Protection and monitoring logic for a four-channel class-D amplifier.
// Assumes comparator inputs synchronous to core_clk and an external I2C slave
// that presents register reads and writes on the plain register port.
//
// Behaviour
// - Cut PWM pulse on current cap, keep playing
// - Current cap only warns: caution pin, status
// - Per-channel limiting; cap level from 0x01 bit4
// - Overcurrent trip: Hi-Z, record, error pin
// - After clear, diagnose; retry every second
// - Diagnostics off: Hi-Z until host clears
// - DC offset: Hi-Z, record, error pin
// - Mask hides DC offset from error pin
// - Clip after window count of full-duty cycles
// - Clip latches by default, pin routing maskable
// - Non-latching clip follows full duty live
// - Four thermal caution levels, maskable caution pin
// - Global thermal trip: all Hi-Z, error pin
// - Thermal trip holds unless auto-recovery selected
// - Error pin stays until clear after trip
// - Channel caution sets 0x13 bit, caution pin
// - Channel thermal trip Hi-Z; auto-recovers below caution
// - Supply low raises error pin and status
// - Restart resets registers and status
// - Restart sets restart warning and caution pin
// - Supply high raises error pin and status
// - Error reports hold until clear written
// - Caution pin latches until clear written
// - Masks gate only the alert pins, default unmasked
`timescale 1ns/100ps
module apf_fault_manager
    import apf_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = DIAG_RETRY_MS * 1000000 / CLK_PERIOD_NS
) (
    // Clock and power-on restart
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Register port from the I2C slave
    input  wire logic [7:0]         regAddr,
    input  wire logic [7:0]         regWrData,
    input  wire logic               regWrEn,
    input  wire logic               regRdEn,
    output logic      [7:0]         regRdData,
    // Per-channel monitors
    input  wire logic [NUM_CH-1:0]  capHit,
    input  wire logic [NUM_CH-1:0]  tripHit,
    input  wire logic [NUM_CH-1:0]  dcOffsetHit,
    input  wire logic               pwmTick,
    input  wire logic [NUM_CH-1:0]  dutyFull,
    input  wire logic [NUM_CH-1:0]  chanCautionHot,
    input  wire logic [NUM_CH-1:0]  chanTripHot,
    // Global monitors
    input  wire logic [3:0]         tempAbove,
    input  wire logic               globalTripHot,
    input  wire logic               outSupplyLow,
    input  wire logic               batSupplyLow,
    input  wire logic               outSupplyHigh,
    // Load diagnostic engine
    input  wire logic [NUM_CH-1:0]  diagDone,
    input  wire logic [NUM_CH-1:0]  diagPass,
    output logic      [NUM_CH-1:0]  diagStart,
    // Output stage control
    output logic      [NUM_CH-1:0]  pulseCut,
    output logic      [NUM_CH-1:0]  chanHiZ,
    output logic                    capLevelSel,
    // Open-drain alert pins
    output logic                    errPinOut,
    output logic                    errPinOeN,
    output logic                    cautionPinOut,
    output logic                    cautionPinOeN
);

    typedef struct packed {
        logic [7:0]                    miscOne;
        logic [7:0]                    masks;
        logic                          autoRecover;
        logic                          clipNoLatch;
        logic                          diagEn;
        logic [7:0]                    clipWin;
        logic                          clearPend;
        logic [NUM_CH-1:0]             ocErr;
        logic [NUM_CH-1:0]             dcErr;
        logic [NUM_CH-1:0]             chanTripErr;
        logic [NUM_CH-1:0]             chanCaution;
        logic [NUM_CH-1:0]             capStat;
        logic [3:0]                    globErr;
        logic                          globCaution;
        logic                          restartWarn;
        logic                          clipFlag;
        logic                          thermShut;
        logic [NUM_CH-1:0]             chanShut;
        apf_oc_state_t [NUM_CH-1:0]    ocState;
        logic [NUM_CH-1:0][26:0]       ocTimer;
        logic [NUM_CH-1:0][7:0]        clipCnt;
        logic [7:0]                    rdData;
        logic [NUM_CH-1:0]             hiZ;
        logic [NUM_CH-1:0]             pulseCut;
        logic [NUM_CH-1:0]             diagStart;
        logic                          errOeN;
        logic                          cautionOeN;
        logic                          errOut;
        logic                          cautionOut;
    } apf_state_t;

    apf_state_t s_q;
    apf_state_t s_d;

    logic                 clearNow;
    logic [NUM_CH-1:0]    clipNow;
    logic                 cautionHot;
    logic                 errSet;
    logic                 cautionSet;
    logic [1:0]           cautionSel;

    // Fault sources after masking, except supplyFault, which is raw
    logic                 supplyFault;
    logic                 errOcSrc;
    logic                 errDcSrc;
    logic                 errThermSrc;
    logic                 errSupplySrc;
    // Caution sources after masking
    logic                 cautionClipSrc;
    logic                 cautionHotSrc;
    logic                 cautionCapSrc;

    always_comb begin
        s_d        = s_q;
        clearNow   = s_q.clearPend;
        clipNow    = '0;
        cautionSel = s_q.miscOne[M1_CAUTION_LO+1:M1_CAUTION_LO];
        cautionHot = tempAbove[cautionSel];
        s_d.clearPend = 1'b0;
        s_d.diagStart = '0;

        // Supply faults force every channel to Hi-Z
        supplyFault = outSupplyLow || batSupplyLow || outSupplyHigh;

        // Register writes
        if (regWrEn) begin
            if (regAddr == ADDR_MISC_ONE) begin
                s_d.miscOne = regWrData;
            end else if (regAddr == ADDR_PIN_MASKS) begin
                s_d.masks = regWrData;
            end else if (regAddr == ADDR_MISC_THREE) begin
                s_d.clearPend   = regWrData[M3_CLEAR];
                s_d.autoRecover = regWrData[M3_AUTO_RECOVER];
                s_d.clipNoLatch = regWrData[M3_CLIP_NOLATCH];
                s_d.diagEn      = regWrData[M3_DIAG_EN];
            end else if (regAddr == ADDR_CLIP_WIN) begin
                s_d.clipWin = regWrData;
            end
        end

        // Sticky status: clear first, events win
        if (clearNow) begin
            s_d.ocErr       = '0;
            s_d.dcErr       = '0;
            s_d.chanTripErr = '0;
            s_d.chanCaution = '0;
            s_d.capStat     = '0;
            s_d.globErr     = '0;
            s_d.globCaution = 1'b0;
            s_d.restartWarn = 1'b0;
            s_d.clipFlag    = 1'b0;
        end
        s_d.capStat     = s_d.capStat | capHit;
        s_d.ocErr       = s_d.ocErr | tripHit;
        s_d.dcErr       = s_d.dcErr | dcOffsetHit;
        s_d.chanTripErr = s_d.chanTripErr | chanTripHot;
        s_d.chanCaution = s_d.chanCaution | chanCautionHot;
        s_d.globCaution = s_d.globCaution | cautionHot;
        s_d.globErr[GE_OUT_LOW] = s_d.globErr[GE_OUT_LOW] | outSupplyLow;
        s_d.globErr[GE_BAT_LOW] = s_d.globErr[GE_BAT_LOW] | batSupplyLow;
        s_d.globErr[GE_HIGH]    = s_d.globErr[GE_HIGH] | outSupplyHigh;
        s_d.globErr[GE_THERM]   = s_d.globErr[GE_THERM] | globalTripHot;

        // Clip window counting per channel
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (!dutyFull[ch]) begin
                s_d.clipCnt[ch] = '0;
            end else if (pwmTick && s_q.clipCnt[ch] != 8'hFF) begin
                s_d.clipCnt[ch] = s_q.clipCnt[ch] + 8'h01;
            end
            clipNow[ch] = dutyFull[ch] && (s_q.clipCnt[ch] >= s_q.clipWin);
        end
        if (s_q.clipNoLatch) begin
            s_d.clipFlag = |clipNow;
        end else begin
            s_d.clipFlag = s_d.clipFlag | (|clipNow);
        end

        // Global thermal shutdown
        if (globalTripHot) begin
            s_d.thermShut = 1'b1;
        end else if (s_q.autoRecover || clearNow) begin
            s_d.thermShut = 1'b0;
        end

        // Per-channel thermal shutdown and overcurrent retry
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (chanTripHot[ch]) begin
                s_d.chanShut[ch] = 1'b1;
            end else if ((s_q.autoRecover && !chanCautionHot[ch]) || clearNow) begin
                s_d.chanShut[ch] = 1'b0;
            end

            case (s_q.ocState[ch])
                OC_PLAY: begin
                    if (tripHit[ch]) begin
                        s_d.ocState[ch] = OC_TRIPPED;
                    end
                end
                OC_TRIPPED: begin
                    if (clearNow && !tripHit[ch]) begin
                        if (s_q.diagEn) begin
                            s_d.ocState[ch]   = OC_DIAG;
                            s_d.diagStart[ch] = 1'b1;
                        end else begin
                            s_d.ocState[ch] = OC_PLAY;
                        end
                    end
                end
                OC_DIAG: begin
                    if (diagDone[ch]) begin
                        if (diagPass[ch]) begin
                            s_d.ocState[ch] = OC_PLAY;
                        end else begin
                            s_d.ocState[ch] = OC_WAIT;
                            s_d.ocTimer[ch] = '0;
                        end
                    end
                end
                OC_WAIT: begin
                    if (s_q.ocTimer[ch] >= 27'(RETRY_CYCLES - 1)) begin
                        s_d.ocState[ch]   = OC_DIAG;
                        s_d.diagStart[ch] = 1'b1;
                    end else begin
                        s_d.ocTimer[ch] = s_q.ocTimer[ch] + 27'd1;
                    end
                end
                default: begin
                    s_d.ocState[ch] = OC_TRIPPED;
                end
            endcase

            s_d.hiZ[ch] = (s_d.ocState[ch] != OC_PLAY) || s_d.dcErr[ch]
                        || s_d.chanShut[ch] || s_d.thermShut
                        || supplyFault;
        end

        // Pulse truncation while still playing
        s_d.pulseCut = capHit & ~s_d.hiZ;

        // Error pin: masks gate only the pin
        errOcSrc     = (|s_d.ocErr) && !s_q.masks[MK_OC];
        errDcSrc     = (|s_d.dcErr) && !s_q.masks[MK_DC];
        errThermSrc  = (s_d.globErr[GE_THERM] || (|s_d.chanTripErr))
                     && !s_q.masks[MK_THERM];
        errSupplySrc = (|s_d.globErr[GE_HIGH:GE_OUT_LOW]) && !s_q.masks[MK_SUPPLY];
        errSet       = errOcSrc || errDcSrc || errThermSrc || errSupplySrc;
        if (errSet) begin
            s_d.errOeN = 1'b0;
        end else if (clearNow) begin
            s_d.errOeN = 1'b1;
        end

        // Caution pin latches until clear
        cautionClipSrc = s_d.clipFlag && !s_q.masks[MK_CLIP];
        cautionHotSrc  = (s_d.globCaution || (|s_d.chanCaution))
                       && !s_q.masks[MK_CAUTION];
        cautionCapSrc  = (|s_d.capStat) && !s_q.masks[MK_CAP];
        cautionSet     = cautionClipSrc || cautionHotSrc || cautionCapSrc
                       || s_d.restartWarn;
        if (cautionSet) begin
            s_d.cautionOeN = 1'b0;
        end else if (clearNow) begin
            s_d.cautionOeN = 1'b1;
        end

        // Open-drain data stays low; only the enables move
        s_d.errOut     = 1'b0;
        s_d.cautionOut = 1'b0;

        // Register reads
        s_d.rdData = 8'h00;
        if (regRdEn) begin
            if (regAddr == ADDR_MISC_ONE) begin
                s_d.rdData = s_q.miscOne;
            end else if (regAddr == ADDR_OC_ERR) begin
                s_d.rdData = {4'h0, s_q.ocErr};
            end else if (regAddr == ADDR_CH_ERR) begin
                s_d.rdData = {s_q.chanTripErr, s_q.dcErr};
            end else if (regAddr == ADDR_GLOB_ERR) begin
                s_d.rdData = {4'h0, s_q.globErr};
            end else if (regAddr == ADDR_WARN_FLAGS) begin
                s_d.rdData = {1'b0, s_q.clipFlag, s_q.restartWarn, s_q.globCaution, s_q.chanCaution};
            end else if (regAddr == ADDR_PIN_MASKS) begin
                s_d.rdData = s_q.masks;
            end else if (regAddr == ADDR_MISC_THREE) begin
                s_d.rdData = {4'h0, s_q.autoRecover, s_q.clipNoLatch, 1'b0, s_q.diagEn};
            end else if (regAddr == ADDR_CLIP_WIN) begin
                s_d.rdData = s_q.clipWin;
            end else if (regAddr == ADDR_CAP_STAT) begin
                s_d.rdData = {4'h0, s_q.capStat};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q             <= '0;
            s_q.miscOne     <= RST_MISC_ONE;
            s_q.masks       <= RST_PIN_MASKS;
            s_q.clipWin     <= RST_CLIP_WIN;
            s_q.diagEn      <= RST_DIAG_EN;
            s_q.restartWarn <= 1'b1;
            s_q.cautionOeN  <= 1'b0;
            s_q.errOeN      <= 1'b1;
            s_q.errOut      <= 1'b0;
            s_q.cautionOut  <= 1'b0;
            s_q.hiZ         <= '1;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                s_q.ocState[ch] <= OC_PLAY;
            end
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdData     = s_q.rdData;
    assign diagStart     = s_q.diagStart;
    assign pulseCut      = s_q.pulseCut;
    assign chanHiZ       = s_q.hiZ;
    assign capLevelSel   = s_q.miscOne[M1_CAP_LEVEL];
    assign errPinOut     = s_q.errOut;
    assign errPinOeN     = s_q.errOeN;
    assign cautionPinOut = s_q.cautionOut;
    assign cautionPinOeN = s_q.cautionOeN;

endmodule : apf_fault_manager

/* apf_checker.sv */
// Port-level assertions for the fault manager.
// Bound into apf_fault_manager; one core clock domain.
`timescale 1ns/100ps
module apf_checker
    import apf_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = 50
) (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rst_n,
    // Register port
    input wire logic [7:0]        regAddr,
    input wire logic [7:0]        regWrData,
    input wire logic              regWrEn,
    input wire logic              regRdEn,
    input wire logic [7:0]        regRdData,
    // Monitors
    input wire logic [NUM_CH-1:0] capHit,
    input wire logic [NUM_CH-1:0] tripHit,
    input wire logic              globalTripHot,
    input wire logic              outSupplyLow,
    input wire logic              batSupplyLow,
    input wire logic              outSupplyHigh,
    // Outputs
    input wire logic [NUM_CH-1:0] diagStart,
    input wire logic [NUM_CH-1:0] pulseCut,
    input wire logic [NUM_CH-1:0] chanHiZ,
    input wire logic              errPinOeN,
    input wire logic              cautionPinOeN
);
    logic [7:0] maskQ;
    logic       wrClr;
    assign wrClr = regWrEn && regAddr == ADDR_MISC_THREE && regWrData[M3_CLEAR];
    // Shadow of the pin masks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            maskQ <= RST_PIN_MASKS;
        end else if (regWrEn && regAddr == ADDR_PIN_MASKS) begin
            maskQ <= regWrData;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    cap_cut_a: assert property ((capHit[1] && !chanHiZ[1]) [*2] |-> pulseCut[1])
        else $error("current cap did not cut the pulse");
    cap_warn_a: assert property (capHit[1] && !maskQ[MK_CAP] |-> ##[1:2] !cautionPinOeN)
        else $error("current cap gave no caution");
    trip_hiz_a: assert property (tripHit[2] |-> ##[1:2] chanHiZ[2])
        else $error("overcurrent trip left channel driving");
    glob_trip_a: assert property (globalTripHot |-> ##[1:2] (chanHiZ == 4'hF))
        else $error("thermal trip left a channel driving");
    err_hold_a: assert property (!errPinOeN |=> !errPinOeN || $past(wrClr, 2))
        else $error("error pin released without clear");
    caution_hold_a: assert property (!cautionPinOeN |=> !cautionPinOeN || $past(wrClr, 2))
        else $error("caution pin released without clear");
    rd_idle_a: assert property (!regRdEn |=> regRdData == 8'h00)
        else $error("read data not idle");
    diag_pulse_a: assert property (diagStart[2] |-> chanHiZ[2] ##1 !diagStart[2])
        else $error("bad diagnostic start pulse");
    supply_err_a: assert property ((outSupplyLow || batSupplyLow || outSupplyHigh) && !maskQ[MK_SUPPLY]
        |-> ##[1:2] !errPinOeN)
        else $error("supply fault gave no error pin");
endmodule : apf_checker

bind apf_fault_manager apf_checker #(.RETRY_CYCLES(RETRY_CYCLES)) apf_checker_i (
    .core_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .capHit,
    .tripHit, .globalTripHot, .outSupplyLow, .batSupplyLow, .outSupplyHigh, .diagStart,
    .pulseCut, .chanHiZ, .errPinOeN, .cautionPinOeN);

/* apf_host.sv */
// Host model: drives the register port from the falling edge.
// Assumes one core clock and a one-cycle read latency.
`timescale 1ns/100ps
module apf_host (
    // Clock
    input  wire logic       core_clk,
    // Register port
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrEn,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData
);
    initial begin
        {regAddr, regWrData, regWrEn, regRdEn} = '0;
    end
    // One-cycle register write; clears may come while a cause is still active
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask : rd
endmodule : apf_host

/* tb_top.sv */
// Self-checking bench for the fault manager.
// Monitors driven at the falling edge; host model owns the register port.
`timescale 1ns/100ps
module tb_top;
    import apf_pkg::*;
    localparam int unsigned RETRY = 50;
    logic       core_clk, rst_n, regWrEn, regRdEn, pwmTick, globalTripHot;
    logic       outSupplyLow, batSupplyLow, outSupplyHigh, capLevelSel;
    logic       errPinOut, errPinOeN, cautionPinOut, cautionPinOeN;
    logic [7:0] regAddr, regWrData, regRdData, m3, rv;
    logic [3:0] capHit, tripHit, dcOffsetHit, dutyFull, chanCautionHot, chanTripHot;
    logic [3:0] tempAbove, diagDone, diagPass, diagStart, pulseCut, chanHiZ;
    int         mismatches, cmp_count, n;

    apf_fault_manager #(.RETRY_CYCLES(RETRY)) apf_fault_manager_i (.*);
    apf_host apf_host_i (.core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        print_verdict();
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apf_host_i.rd(a, rv);
        chk(rv, e);
    endtask : rdc
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc
    task automatic clr();
        apf_host_i.wr(ADDR_MISC_THREE, m3 | 8'h80);
        cyc(2);
    endtask : clr
    task automatic tick(input int k);
        repeat (k) begin
            @(negedge core_clk);
            pwmTick = 1'b1;
            @(negedge core_clk);
            pwmTick = 1'b0;
        end
        cyc(2);
    endtask : tick
    task automatic waitDiag();
        n = 0;
        while (diagStart[2] !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
    endtask : waitDiag
    task automatic diagAnswer(input logic [3:0] ok);
        @(negedge core_clk);
        diagDone = 4'h4;
        diagPass = ok;
        @(negedge core_clk);
        diagDone = 4'h0;
    endtask : diagAnswer
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        rst_n = 1'b0;
        {capHit, tripHit, dcOffsetHit, dutyFull, chanCautionHot, chanTripHot, tempAbove} = '0;
        {globalTripHot, outSupplyLow, batSupplyLow, outSupplyHigh, pwmTick, diagDone, diagPass} = '0;
        m3 = 8'h01;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        chk(8'(cautionPinOeN), 8'h00);
        rdc(ADDR_WARN_FLAGS, 8'h20);
        rdc(ADDR_MISC_THREE, 8'h01);
        apf_host_i.wr(8'h30, 8'hA5);
        apf_host_i.wr(ADDR_WARN_FLAGS, 8'hFF);
        rdc(8'h30, 8'h00);
        clr();
        chk(8'(cautionPinOeN), 8'h01);
        rdc(ADDR_WARN_FLAGS, 8'h00);
        apf_host_i.wr(ADDR_MISC_ONE, 8'h10);
        capHit = 4'h2;
        cyc(3);
        chk(8'(capLevelSel), 8'h01);
        chk(8'(pulseCut), 8'h02);
        chk(8'(chanHiZ), 8'h00);
        chk(8'(errPinOeN), 8'h01);
        capHit = 4'h0;
        rdc(ADDR_CAP_STAT, 8'h02);
        rdc(ADDR_OC_ERR, 8'h00);
        clr();
        dutyFull = 4'h1;
        tick(19);
        rdc(ADDR_WARN_FLAGS, 8'h00);
        tick(1);
        dutyFull = 4'h0;
        cyc(2);
        rdc(ADDR_WARN_FLAGS, 8'h40);
        chk(8'(cautionPinOeN), 8'h00);
        m3 = 8'h05;
        clr();
        apf_host_i.wr(ADDR_PIN_MASKS, 8'h01);
        dutyFull = 4'h8;
        tick(20);
        rdc(ADDR_WARN_FLAGS, 8'h40);
        chk(8'(cautionPinOeN), 8'h01);
        dutyFull = 4'h0;
        cyc(2);
        rdc(ADDR_WARN_FLAGS, 8'h00);
        m3 = 8'h01;
        tripHit = 4'h4;
        cyc(2);
        tripHit = 4'h0;
        cyc(5);
        chk(8'(chanHiZ), 8'h04);
        chk(8'(errPinOeN), 8'h00);
        chk({6'h0, errPinOut, cautionPinOut}, 8'h00);
        rdc(ADDR_OC_ERR, 8'h04);
        apf_host_i.wr(ADDR_MISC_THREE, 8'h81);
        waitDiag();
        chk(8'(n < 200), 8'h01);
        diagAnswer(4'h0);
        waitDiag();
        chk(8'(n >= RETRY - 4 && n <= RETRY + 4), 8'h01);
        chk(8'(chanHiZ), 8'h04);
        diagAnswer(4'h4);
        cyc(3);
        chk(8'(chanHiZ), 8'h00);
        m3 = 8'h00;
        apf_host_i.wr(ADDR_MISC_THREE, m3);
        tripHit = 4'h2;
        cyc(2);
        tripHit = 4'h0;
        cyc(RETRY + 10);
        chk(8'(chanHiZ), 8'h02);
        clr();
        cyc(2);
        chk(8'(chanHiZ), 8'h00);
        apf_host_i.wr(ADDR_PIN_MASKS, 8'h08);
        dcOffsetHit = 4'h8;
        cyc(3);
        chk(8'(chanHiZ), 8'h08);
        chk(8'(errPinOeN), 8'h01);
        dcOffsetHit = 4'h0;
        rdc(ADDR_CH_ERR, 8'h08);
        m3 = 8'h08;
        clr();
        globalTripHot = 1'b1;
        cyc(3);
        chk(8'(chanHiZ), 8'h0F);
        globalTripHot = 1'b0;
        cyc(4);
        chk(8'(chanHiZ), 8'h00);
        chk(8'(errPinOeN), 8'h00);
        rdc(ADDR_GLOB_ERR, 8'h08);
        chanTripHot = 4'h1;
        chanCautionHot = 4'h3;
        tempAbove = 4'h1;
        cyc(3);
        chanTripHot = 4'h0;
        cyc(3);
        chk(8'(chanHiZ), 8'h01);
        rdc(ADDR_WARN_FLAGS, 8'h13);
        chk(8'(cautionPinOeN), 8'h00);
        apf_host_i.wr(ADDR_PIN_MASKS, 8'h02);
        chanCautionHot = 4'h2;
        m3 = 8'h00;
        clr();
        chk(8'(chanHiZ), 8'h00);
        chk(8'(cautionPinOeN), 8'h01);
        rdc(ADDR_WARN_FLAGS, 8'h12);
        {chanCautionHot, tempAbove} = '0;
        globalTripHot = 1'b1;
        cyc(3);
        globalTripHot = 1'b0;
        cyc(5);
        chk(8'(chanHiZ), 8'h0F);
        clr();
        for (int i = 0; i < 3; i++) begin
            {outSupplyHigh, batSupplyLow, outSupplyLow} = 3'(1 << i);
            cyc(3);
            chk(8'(errPinOeN), 8'h00);
            {outSupplyHigh, batSupplyLow, outSupplyLow} = 3'h0;
            rdc(ADDR_GLOB_ERR, 8'(1 << i));
            clr();
        end
        apf_host_i.wr(ADDR_MISC_ONE, 8'h40);
        tempAbove = 4'h3;
        rdc(ADDR_WARN_FLAGS, 8'h00);
        tempAbove = 4'h4;
        rdc(ADDR_WARN_FLAGS, 8'h10);
        tempAbove = 4'h0;
        apf_host_i.wr(ADDR_CLIP_WIN, 8'h05);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        rdc(ADDR_CLIP_WIN, 8'h14);
        rdc(ADDR_PIN_MASKS, 8'h00);
        rdc(ADDR_WARN_FLAGS, 8'h20);
        print_verdict();
    end
endmodule : tb_top
